// ### src/chbs_top.sv
// card host bus setup sequencer: registers, clock, power, width, timeout
`timescale 1ns/10ps
`default_nettype none
// Contract
// - write one clears presence status flags
// - stable flag rises once clock settles
// - card clock enable starts bus clock
// - clearing card clock enable stops clock
// - voltage and power accepted together
// - width bit selects driven data lanes
// - timeout counter value flags data timeouts
module chbs_top
#(
    parameter logic [5:0] BASE_CLK_MHZ = 6'h32,  // base clock capability
    parameter logic [5:0] TOUT_CLK_FREQ = 6'h10, // timeout clock capability
    parameter logic       TOUT_CLK_MHZ = 1'b1,   // timeout clock unit
    parameter logic [2:0] VOLT_SUPPORT = 3'h1    // 3.3, 3.0, 1.8 support mask
)
(
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    input  wire logic [chbs_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [chbs_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    input  wire logic                    card_detect_n,
    input  wire logic                    tmclk,
    input  wire logic                    cmd_inhibit,
    input  wire logic                    data_line_inhibit,
    input  wire logic                    data_busy,
    input  wire logic                    dat_drive_en,
    input  wire logic [3:0]              dat_drive_val,
    output logic                         card_clk_out,
    output logic                         bus_power_out,
    output logic [2:0]                   bus_voltage_out,
    output logic [3:0]                   dat_out,
    output logic [3:0]                   dat_oe_n
);
    import chbs_pkg::*;

    // byte-lane merge for register writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (strb[i])
                r[i*8 +: 8] = nw[i*8 +: 8];
        return r;
    endfunction

    // voltage code supported by this slot
    function automatic logic vsel_ok(input logic [2:0] v);
        return (v == VSEL_33 && VOLT_SUPPORT[0]) || (v == VSEL_30 && VOLT_SUPPORT[1])
            || (v == VSEL_18 && VOLT_SUPPORT[2]);
    endfunction

    chbs_div_if dif();                       // carrier to the divider
    chbs_clk_div u_div (.clk(clk), .reset_n(reset_n), .dif(dif));

    // pin synchronisers, two stages each
    logic [1:0] sync1_q;                     // first stage, read by second only
    logic [1:0] sync2_q;                     // bit1 card present, bit0 timeout clock
    logic       tm_prev_q;                   // previous timeout clock level
    logic       present_prev_q;              // previous card present level
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sync1_q        <= '0;
            sync2_q        <= '0;
            tm_prev_q      <= 1'b0;
            present_prev_q <= 1'b0;
        end
        else
        begin
            sync1_q        <= {~card_detect_n, tmclk};
            sync2_q        <= sync1_q;
            tm_prev_q      <= sync2_q[0];
            present_prev_q <= sync2_q[1];
        end
    end
    logic card_present;
    logic tm_edge;
    assign card_present = sync2_q[1];
    assign tm_edge      = sync2_q[0] && !tm_prev_q;

    // software-visible state
    logic [31:0]          clk_reg_q, clk_reg_d;      // clock control image
    logic                 pwr_on_q, pwr_on_d;
    logic [VSEL_W-1:0]    vsel_q, vsel_d;
    logic                 width4_q, width4_d;        // 4-bit data mode
    logic [TOUT_W-1:0]    tout_q, tout_d;
    logic [31:0]          int_q, int_d;              // sticky status
    logic [31:0]          int_en_q, int_en_d;        // status enables
    chbs_clk_state_type   cst_q, cst_d;              // internal clock state
    logic [STABLE_CNT_W-1:0] scnt_q, scnt_d;         // settle counter
    logic [TOUT_CNT_W-1:0] tcnt_q, tcnt_d;           // timeout clock edges
    logic                 power_pin_q, power_pin_d;
    logic [3:0]           dout_q, dout_d;
    logic [3:0]           doe_n_q, doe_n_d;
    logic                 bvalid_q, bvalid_d;
    logic [1:0]           bresp_q, bresp_d;
    logic                 rvalid_q, rvalid_d;
    logic [31:0]          rdata_q, rdata_d;
    logic [1:0]           rresp_q, rresp_d;

    logic wr_fire, rd_fire, int_en_bit, stable, ins_evt, rem_evt, dto_hit;
    logic [TOUT_CNT_W-1:0] tlimit;
    logic [3:0] tsel;

    // address and data are taken together, one write outstanding at a time
    assign wr_fire    = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
    assign rd_fire    = s_axi_arvalid && !rvalid_q;
    assign int_en_bit = clk_reg_q[CLK_INT_EN_BIT];
    assign stable     = (cst_q == CLK_RUN);
    assign ins_evt    = card_present && !present_prev_q && int_en_q[INT_INS_BIT];
    assign rem_evt    = !card_present && present_prev_q && int_en_q[INT_REM_BIT];
    // codes above the top step saturate rather than wrap to a short window
    assign tsel       = (tout_q > TOUT_MAX) ? TOUT_MAX : tout_q;
    assign tlimit     = TOUT_CNT_W'(1) << (TOUT_BASE_EXP + tsel);
    assign dto_hit    = data_busy && tm_edge && (tcnt_q == tlimit - 1'b1) &&
                        int_en_q[INT_DTO_BIT];

    // next-state logic for registers, sequencer and bus answers
    always_comb
    begin
        clk_reg_d = clk_reg_q;
        pwr_on_d  = pwr_on_q;
        vsel_d    = vsel_q;
        width4_d  = width4_q;
        tout_d    = tout_q;
        int_d     = int_q;
        int_en_d  = int_en_q;
        cst_d     = cst_q;
        scnt_d    = scnt_q;
        tcnt_d    = tcnt_q;
        bvalid_d  = bvalid_q && !s_axi_bready;
        bresp_d   = bresp_q;
        rvalid_d  = rvalid_q && !s_axi_rready;
        rdata_d   = rdata_q;
        rresp_d   = rresp_q;
        if (wr_fire)
        begin
            bvalid_d = 1'b1;
            bresp_d  = RESP_OKAY;
            case (s_axi_awaddr)
                ADDR_CLK:    clk_reg_d = merge(clk_reg_q, s_axi_wdata, s_axi_wstrb);
                ADDR_PWR:    // both fields land in the same access
                begin
                    if (s_axi_wstrb[0])
                    begin
                        pwr_on_d = s_axi_wdata[PWR_ON_BIT];
                        vsel_d   = s_axi_wdata[PWR_VSEL_LSB +: VSEL_W];
                    end
                end
                ADDR_HOST:   if (s_axi_wstrb[0]) width4_d = s_axi_wdata[HOST_WIDTH_BIT];
                ADDR_TOUT:   if (s_axi_wstrb[0]) tout_d = s_axi_wdata[TOUT_W-1:0];
                ADDR_INT:    int_d = int_q & ~merge(32'h0, s_axi_wdata, s_axi_wstrb);
                ADDR_INT_EN: int_en_d = merge(int_en_q, s_axi_wdata, s_axi_wstrb);
                ADDR_PRES, ADDR_CAPS: ;                       // read-only, write ignored
                default:     bresp_d = RESP_SLVERR;           // unmapped address
            endcase
        end
        // hardware sets win over a clearing write in the same cycle
        if (ins_evt) int_d[INT_INS_BIT] = 1'b1;
        if (rem_evt) int_d[INT_REM_BIT] = 1'b1;
        if (dto_hit) int_d[INT_DTO_BIT] = 1'b1;
        clk_reg_d[CLK_STABLE_BIT] = 1'b0;                     // status bit not stored
        // data timeout: count timeout clock edges while data is awaited
        if (!data_busy || dto_hit)
            tcnt_d = '0;
        else if (tm_edge)
            tcnt_d = tcnt_q + 1'b1;
        // internal clock settles for a fixed time after enable
        case (cst_q)
            CLK_OFF:
            begin
                scnt_d = '0;
                if (int_en_bit) cst_d = CLK_WAIT;
            end
            CLK_WAIT:
            begin
                scnt_d = scnt_q + 1'b1;
                if (!int_en_bit) cst_d = CLK_OFF;
                else if (scnt_q == STABLE_CNT_W'(STABLE_CYCLES - 1)) cst_d = CLK_RUN;
            end
            CLK_RUN:     if (!int_en_bit) cst_d = CLK_OFF;
            default:     cst_d = CLK_OFF;
        endcase
        if (rd_fire)
        begin
            rvalid_d = 1'b1;
            rresp_d  = RESP_OKAY;
            rdata_d  = '0;
            case (s_axi_araddr)
                ADDR_CLK:
                begin
                    rdata_d = clk_reg_q;
                    rdata_d[CLK_STABLE_BIT] = stable;
                end
                ADDR_PWR:    rdata_d[VSEL_W:0] = {vsel_q, pwr_on_q};
                ADDR_HOST:   rdata_d[HOST_WIDTH_BIT] = width4_q;
                ADDR_TOUT:   rdata_d[TOUT_W-1:0] = tout_q;
                ADDR_INT:    rdata_d = int_q;
                ADDR_INT_EN: rdata_d = int_en_q;
                ADDR_PRES:
                begin
                    rdata_d[PRES_CMD_BIT]  = cmd_inhibit;
                    rdata_d[PRES_DAT_BIT]  = data_line_inhibit;
                    rdata_d[PRES_CARD_BIT] = card_present;
                end
                ADDR_CAPS:
                begin
                    rdata_d[CAP_TFREQ_LSB +: 6] = TOUT_CLK_FREQ;
                    rdata_d[CAP_TUNIT_BIT]      = TOUT_CLK_MHZ;
                    rdata_d[CAP_BASE_LSB +: 6]  = BASE_CLK_MHZ;
                    rdata_d[CAP_V33_BIT]        = VOLT_SUPPORT[0];
                    rdata_d[CAP_V30_BIT]        = VOLT_SUPPORT[1];
                    rdata_d[CAP_V18_BIT]        = VOLT_SUPPORT[2];
                end
                default:     rresp_d = RESP_SLVERR;
            endcase
        end
        // pin images: power only with a supported code, lanes by width
        power_pin_d = pwr_on_q && vsel_ok(vsel_q);
        dout_d      = dat_drive_val;
        doe_n_d     = dat_drive_en ? ~(width4_q ? LANES_4BIT : LANES_1BIT) : 4'hF;
    end

    // state registers
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            clk_reg_q   <= '0;
            pwr_on_q    <= 1'b0;
            vsel_q      <= '0;
            width4_q    <= 1'b0;
            tout_q      <= '0;
            int_q       <= '0;
            int_en_q    <= '0;
            cst_q       <= CLK_OFF;
            scnt_q      <= '0;
            tcnt_q      <= '0;
            power_pin_q <= 1'b0;
            dout_q      <= '0;
            doe_n_q     <= 4'hF;
            bvalid_q    <= 1'b0;
            bresp_q     <= RESP_OKAY;
            rvalid_q    <= 1'b0;
            rdata_q     <= '0;
            rresp_q     <= RESP_OKAY;
        end
        else
        begin
            clk_reg_q   <= clk_reg_d;
            pwr_on_q    <= pwr_on_d;
            vsel_q      <= vsel_d;
            width4_q    <= width4_d;
            tout_q      <= tout_d;
            int_q       <= int_d;
            int_en_q    <= int_en_d;
            cst_q       <= cst_d;
            scnt_q      <= scnt_d;
            tcnt_q      <= tcnt_d;
            power_pin_q <= power_pin_d;
            dout_q      <= dout_d;
            doe_n_q     <= doe_n_d;
            bvalid_q    <= bvalid_d;
            bresp_q     <= bresp_d;
            rvalid_q    <= rvalid_d;
            rdata_q     <= rdata_d;
            rresp_q     <= rresp_d;
        end
    end

    // card clock runs only with enable set and the internal clock settled
    assign dif.run         = clk_reg_q[CLK_CARD_EN_BIT] && stable;
    assign dif.div_sel     = clk_reg_q[CLK_DIV_LSB +: DIV_W];
    assign card_clk_out    = dif.card_clk;
    assign bus_power_out   = power_pin_q;
    assign bus_voltage_out = vsel_q;
    assign dat_out         = dout_q;
    assign dat_oe_n        = doe_n_q;
    assign s_axi_awready   = wr_fire;
    assign s_axi_wready    = wr_fire;
    assign s_axi_bvalid    = bvalid_q;
    assign s_axi_bresp     = bresp_q;
    assign s_axi_arready   = rd_fire;
    assign s_axi_rvalid    = rvalid_q;
    assign s_axi_rdata     = rdata_q;
    assign s_axi_rresp     = rresp_q;

    // checks on the block's own behaviour
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_w1c_clears_ins: assert property ((wr_fire && s_axi_awaddr == ADDR_INT && s_axi_wstrb[0]
        && s_axi_wdata[INT_INS_BIT] && !ins_evt) |=> !int_q[INT_INS_BIT])
        else $error("insertion flag not cleared");
    a_stable_settles: assert property ((cst_q == CLK_WAIT && int_en_bit
        && scnt_q == STABLE_CNT_W'(STABLE_CYCLES - 1)) |=> stable)
        else $error("stable flag late");
    a_card_clk_start: assert property ($rose(dif.run) |-> ##[1:300] card_clk_out)
        else $error("card clock did not start");
    a_card_clk_stop: assert property (!clk_reg_q[CLK_CARD_EN_BIT] |=> !card_clk_out)
        else $error("card clock running while disabled");
    a_vsel_power_pair: assert property ((wr_fire && s_axi_awaddr == ADDR_PWR && s_axi_wstrb[0]
        && s_axi_wdata[PWR_ON_BIT] && vsel_ok(s_axi_wdata[PWR_VSEL_LSB +: VSEL_W]))
        |=> ##1 bus_power_out
        && bus_voltage_out == $past(s_axi_wdata[PWR_VSEL_LSB +: VSEL_W], 2))
        else $error("power and voltage not taken together");
    a_width_one_lane: assert property ((dat_drive_en && !width4_q) |=> dat_oe_n == 4'hE)
        else $error("1-bit mode drives extra lanes");
    a_dto_flag_set: assert property (dto_hit |=> int_q[INT_DTO_BIT])
        else $error("data timeout not flagged");
    a_clk_gate_stable: assert property (!stable |=> !card_clk_out)
        else $error("card clock before internal clock stable");
    a_power_gate_vsel: assert property (!vsel_ok(vsel_q) |=> !bus_power_out)
        else $error("power on with unsupported voltage");
    c_insertion: cover property (ins_evt);
    c_clock_stable: cover property ($rose(stable));
    c_data_timeout: cover property (dto_hit);
endmodule
`default_nettype wire

// ### src/chbs_pkg.sv
// constants for the card host bus setup sequencer
package chbs_pkg;
    // clock rate and derived timing counts
    localparam int unsigned CLK_PERIOD_NS   = 5;
    localparam int unsigned STABLE_TIME_NS  = 1000;   // internal clock settle time
    localparam int unsigned STABLE_CYCLES   = (STABLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STABLE_CNT_W    = 8;
    // register byte addresses
    localparam int unsigned ADDR_W          = 8;
    localparam logic [7:0]  ADDR_CLK        = 8'h00;
    localparam logic [7:0]  ADDR_PWR        = 8'h04;
    localparam logic [7:0]  ADDR_HOST       = 8'h08;
    localparam logic [7:0]  ADDR_TOUT       = 8'h0C;
    localparam logic [7:0]  ADDR_INT        = 8'h10;
    localparam logic [7:0]  ADDR_INT_EN     = 8'h14;
    localparam logic [7:0]  ADDR_PRES       = 8'h18;
    localparam logic [7:0]  ADDR_CAPS       = 8'h1C;
    // clock control fields
    localparam int unsigned CLK_INT_EN_BIT  = 0;
    localparam int unsigned CLK_STABLE_BIT  = 1;
    localparam int unsigned CLK_CARD_EN_BIT = 2;
    localparam int unsigned CLK_DIV_LSB     = 8;
    localparam int unsigned DIV_W           = 8;
    // power control fields and voltage codes
    localparam int unsigned PWR_ON_BIT      = 0;
    localparam int unsigned PWR_VSEL_LSB    = 1;
    localparam int unsigned VSEL_W          = 3;
    localparam logic [2:0]  VSEL_18         = 3'h5;
    localparam logic [2:0]  VSEL_30         = 3'h6;
    localparam logic [2:0]  VSEL_33         = 3'h7;
    // host control, timeout control
    localparam int unsigned HOST_WIDTH_BIT  = 1;
    localparam int unsigned TOUT_W          = 4;
    localparam int unsigned TOUT_BASE_EXP   = 13;
    localparam logic [3:0]  TOUT_MAX        = 4'hE;
    localparam int unsigned TOUT_CNT_W      = 28;
    // interrupt status and status-enable bits
    localparam int unsigned INT_INS_BIT     = 6;
    localparam int unsigned INT_REM_BIT     = 7;
    localparam int unsigned INT_DTO_BIT     = 20;
    // present state bits
    localparam int unsigned PRES_CMD_BIT    = 0;
    localparam int unsigned PRES_DAT_BIT    = 1;
    localparam int unsigned PRES_CARD_BIT   = 16;
    // capabilities fields
    localparam int unsigned CAP_TFREQ_LSB   = 0;
    localparam int unsigned CAP_TUNIT_BIT   = 7;
    localparam int unsigned CAP_BASE_LSB    = 8;
    localparam int unsigned CAP_V33_BIT     = 24;
    localparam int unsigned CAP_V30_BIT     = 25;
    localparam int unsigned CAP_V18_BIT     = 26;
    // data lane enables and bus responses
    localparam logic [3:0]  LANES_4BIT      = 4'hF;
    localparam logic [3:0]  LANES_1BIT      = 4'h1;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;
    // internal clock sequencer, one-hot
    typedef enum logic [2:0] {
        CLK_OFF  = 3'h1,
        CLK_WAIT = 3'h2,
        CLK_RUN  = 3'h4
    } chbs_clk_state_type;
endpackage

// ### src/chbs_div_if.sv
// carrier between the sequencer and the card clock divider
`timescale 1ns/10ps
`default_nettype none
interface chbs_div_if;
    logic       run;       // divider may toggle the card clock
    logic [7:0] div_sel;   // half period minus one, in base cycles
    logic       card_clk;  // divided card clock, registered
    modport ctrl (output run, output div_sel, input card_clk);
    modport div  (input run, input div_sel, output card_clk);
endinterface
`default_nettype wire

// ### src/chbs_clk_div.sv
// card clock divider driven from the base clock
`timescale 1ns/10ps
`default_nettype none
module chbs_clk_div
(
    input  wire logic   clk,
    input  wire logic   reset_n,
    chbs_div_if.div     dif
);
    import chbs_pkg::*;

    logic [DIV_W-1:0] cnt_q;     // base cycles in this half period
    logic [DIV_W-1:0] cnt_d;
    logic             sclk_q;    // card clock level
    logic             sclk_d;

    // next values: held low and parked while not running, so a restart
    // always begins with a full low half period and no runt pulse
    always_comb
    begin
        cnt_d  = cnt_q;
        sclk_d = sclk_q;
        if (!dif.run)
        begin
            cnt_d  = '0;
            sclk_d = 1'b0;
        end
        else if (cnt_q >= dif.div_sel)
        begin
            cnt_d  = '0;
            sclk_d = ~sclk_q;
        end
        else
        begin
            cnt_d = cnt_q + 1'b1;
        end
    end

    // state registers
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cnt_q  <= '0;
            sclk_q <= 1'b0;
        end
        else
        begin
            cnt_q  <= cnt_d;
            sclk_q <= sclk_d;
        end
    end

    assign dif.card_clk = sclk_q;
endmodule
`default_nettype wire

// ### bench/chbs_card_model.sv
// card side model: detect pin, free-running timeout clock, card clock edge count
`timescale 1ns/10ps
`default_nettype none
module chbs_card_model
(
    input  wire logic    insert,
    input  wire logic    card_clk,
    output logic         card_detect_n,
    output logic         tmclk,
    output int unsigned  clk_edges
);
    // the modelled card answers every command, so the re-initialise path is idle
    // card side width is taken as already set by command, with the card unlocked
    // and its interrupt master enable cleared around the change
    // detect pin is low while a card sits in the slot
    assign card_detect_n = !insert;
    // timeout clock runs free at 64 ns, unrelated to the base clock
    initial tmclk = 1'b0;
    always #32 tmclk = ~tmclk;
    // count card clock rising edges so the bench can see start and stop
    initial clk_edges = 0;
    always @(posedge card_clk) clk_edges++;
endmodule
`default_nettype wire

// ### bench/test_card_host_bus_setup_sequencer.sv
// register-level bench for the card host bus setup sequencer
`timescale 1ns/10ps
`default_nettype none
`define chk(n, e, s) begin check_count++; if ((s) !== (e)) begin mismatches++; \
    $display("mismatch %s expected %h seen %h", n, e, s); end end
module test_card_host_bus_setup_sequencer;
    import chbs_pkg::*;
    logic        clk = 1'b0, reset_n = 1'b0, insert = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [1:0]  bresp, rresp, rs, wb;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        cmd_inh = 0, dat_inh = 0, busy = 0, drv_en = 0;
    logic        card_detect_n, tmclk, card_clk, pwr;
    logic [2:0]  volt;
    logic [3:0]  dat_out, dat_oe_n;
    logic [3:0]  dval = 4'hA;
    int unsigned mismatches = 0, check_count = 0, cyc = 0, edges, n0, hp;
    always #2.5 clk = ~clk;
    chbs_top dut (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .card_detect_n(card_detect_n), .tmclk(tmclk),
        .cmd_inhibit(cmd_inh), .data_line_inhibit(dat_inh), .data_busy(busy),
        .dat_drive_en(drv_en), .dat_drive_val(dval), .card_clk_out(card_clk),
        .bus_power_out(pwr), .bus_voltage_out(volt), .dat_out(dat_out),
        .dat_oe_n(dat_oe_n));
    chbs_card_model card (.insert(insert), .card_clk(card_clk),
        .card_detect_n(card_detect_n), .tmclk(tmclk), .clk_edges(edges));
    // prints the verdict and ends the run
    task automatic close_out;
        if (mismatches == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // write: address and data offered together, bready held until bvalid
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do @(posedge clk); while (!(awready && wready));
        awvalid <= 1'b0; wvalid <= 1'b0;
        do @(posedge clk); while (!bvalid);
        wb = bresp;
        bready <= 1'b0;
        @(posedge clk);
    endtask
    // read: rdata and rresp taken at the edge where rvalid is seen
    task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clk); while (!rvalid);
        d = rdata; r = rresp; rready <= 1'b0;
        @(posedge clk);
    endtask
    // one high half period of the card clock in base cycles, timed from a low phase
    task automatic half(output int unsigned n);
        while (card_clk !== 1'b0) @(posedge clk);
        while (card_clk !== 1'b1) @(posedge clk);
        n = 0;
        while (card_clk === 1'b1)
        begin
            n++;
            @(posedge clk);
        end
    endtask
    // hang guard: the whole sequence needs well under this many cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            close_out();
        end
    end
    initial
    begin
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rdr(ADDR_CLK, rd, rs); `chk("clk reset", 32'h0, rd)
        rdr(8'h40, rd, rs); `chk("unmapped resp", RESP_SLVERR, rs)
        wr(8'h40, 32'h0); `chk("unmapped wresp", RESP_SLVERR, wb)
        wr(ADDR_INT_EN, 32'h000000C0);
        `chk("write resp", RESP_OKAY, wb)
        insert <= 1'b1; cmd_inh <= 1'b1; dat_inh <= 1'b1;
        repeat (10) @(posedge clk);
        rdr(ADDR_INT, rd, rs); `chk("insert flag", 32'h00000040, rd)
        rdr(ADDR_PRES, rd, rs); `chk("present", 32'h00010003, rd)
        wr(ADDR_INT, 32'h00000040);
        rdr(ADDR_INT, rd, rs); `chk("insert cleared", 32'h0, rd)
        insert <= 1'b0; cmd_inh <= 1'b0; dat_inh <= 1'b0;
        repeat (10) @(posedge clk);
        rdr(ADDR_INT, rd, rs); `chk("remove flag", 32'h00000080, rd)
        wr(ADDR_INT, 32'h00000080);
        rdr(ADDR_CAPS, rd, rs);
        `chk("base clock known", 1'b1, rd[CAP_BASE_LSB +: 6] != 6'h0)
        `chk("timeout clock known", 1'b1, rd[CAP_TFREQ_LSB +: 6] != 6'h0)
        `chk("supports 3.3", 1'b1, rd[CAP_V33_BIT])
        wr(ADDR_TOUT, 32'h0000000E);
        rdr(ADDR_TOUT, rd, rs); `chk("timeout value", 32'h0000000E, rd)
        // card clock enable set early: nothing may toggle before stable
        wr(ADDR_CLK, 32'h00000405);
        repeat (100) @(posedge clk);
        `chk("clock before stable", 0, edges)
        rdr(ADDR_CLK, rd, rs); `chk("not yet stable", 32'h00000405, rd)
        do rdr(ADDR_CLK, rd, rs); while (rd[CLK_STABLE_BIT] !== 1'b1);
        half(hp);
        `chk("half period", 5, hp)
        // stop only with both inhibits clear
        rdr(ADDR_PRES, rd, rs); `chk("inhibits clear", 32'h0, rd)
        wr(ADDR_CLK, 32'h00000401);
        repeat (3) @(posedge clk);
        n0 = edges;
        repeat (30) @(posedge clk);
        `chk("clock stopped", n0, edges)
        `chk("clock low", 1'b0, card_clk)
        wr(ADDR_CLK, 32'h00000205);
        half(hp);
        `chk("new half period", 3, hp)
        wr(ADDR_PWR, {28'h0, VSEL_33, 1'b1});
        repeat (3) @(posedge clk);
        `chk("power on", 1'b1, pwr)
        `chk("voltage", VSEL_33, volt)
        wr(ADDR_PWR, {28'h0, VSEL_33, 1'b0});
        repeat (3) @(posedge clk);
        `chk("power dropped", 1'b0, pwr)
        wr(ADDR_PWR, {28'h0, VSEL_30, 1'b1});
        repeat (3) @(posedge clk);
        `chk("unsupported off", 1'b0, pwr)
        wr(ADDR_INT_EN, 32'h000000C0);
        drv_en <= 1'b1;
        wr(ADDR_HOST, 32'h00000002);
        repeat (2) @(posedge clk);
        `chk("lanes 4bit", 4'h0, dat_oe_n)
        `chk("lane data", 4'hA, dat_out)
        dval <= 4'h5;
        wr(ADDR_HOST, 32'h00000000);
        repeat (2) @(posedge clk);
        `chk("lanes 1bit", 4'hE, dat_oe_n)
        `chk("lane data 1bit", 4'h5, dat_out)
        drv_en <= 1'b0;
        repeat (2) @(posedge clk);
        `chk("lanes idle", 4'hF, dat_oe_n)
        wr(ADDR_INT_EN, 32'h000001C0);
        rdr(ADDR_INT_EN, rd, rs); `chk("card irq unmasked", 32'h000001C0, rd)
        close_out();
    end
endmodule
`default_nettype wire
